// ===== hw/ddr3_ctrl_end.sv
`timescale 1ns/10ps
module ddr3_ctrl_end #(
   parameter int WL         = 5,
   parameter int INIT_RESET = ddr3_timing_pkg::N_RESET,
   parameter int INIT_CKE   = ddr3_timing_pkg::N_CKE
) (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   ddr3_cmd_if.ctrl         mem,
   input  wire logic        req_valid_in,
   input  wire logic        req_write_in,
   input  wire logic        req_ap_in,
   input  wire logic        req_bc4_in,
   input  wire logic [2:0]  req_bank_in,
   input  wire logic [13:0] req_row_in,
   input  wire logic [9:0]  req_col_in,
   input  wire logic        pd_req_in,
   input  wire logic        hot_in,
   input  wire logic        dll_off_in,
   input  wire logic [1:0]  bl_mode_in,
   output logic             req_ack_out,
   output logic [3:0]       refresh_debt_out,
   output logic             pd_active_out,
   output logic             init_done_out
);
   typedef enum logic [2:0] {ST_RESET, ST_CKE, ST_IDLE, ST_ACT, ST_PRE, ST_REF, ST_PD} ctrl_state_e;

   ctrl_state_e state_q;
   logic [3:0]  cmd_q;
   logic [2:0]  ba_q;
   logic [13:0] a_q;
   logic        cke_q;
   logic        mem_rst_q;
   logic [13:0] init_q;
   logic        lat_write_q;
   logic        lat_ap_q;
   logic        lat_bc4_q;
   logic [9:0]  lat_col_q;
   logic [7:0]  refi_q;
   logic        tick;
   logic [3:0]  debt_q;
   logic        dll_prev_q;
   logic        act_go;
   logic        rw_go;
   logic        pre_go;
   logic        ref_go;
   logic        prea_go;
   logic        pd_go;
   logic        pdx_go;
   logic        gt_load;
   logic [13:0] gt_val;
   logic        gt_done;
   logic        pdt_done;
   logic        dll_done;
   logic [7:0]  wr_load;
   logic [7:0]  wr_done;
   logic        must_ref;

   assign must_ref = (debt_q >= 4'(ddr3_timing_pkg::N_POSTPONE_MAX));

   // Decide which command goes out at the coming edge
   always_comb begin
      act_go  = 1'b0;
      rw_go   = 1'b0;
      pre_go  = 1'b0;
      ref_go  = 1'b0;
      prea_go = 1'b0;
      pd_go   = 1'b0;
      pdx_go  = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (gt_done) begin
               if (debt_q != 4'h0 && (must_ref || !req_valid_in)) begin
                  ref_go = 1'b1;
               end else if (pd_req_in && debt_q == 4'h0 && pdt_done) begin
                  pd_go = 1'b1;
               end else if (req_valid_in && wr_done[req_bank_in] && (req_write_in || dll_done)) begin
                  act_go = 1'b1;
               end
            end
         end
         ST_ACT:  rw_go   = gt_done;
         ST_PRE:  pre_go  = gt_done && wr_done[ba_q];
         ST_REF:  prea_go = gt_done;
         ST_PD:   pdx_go  = !pd_req_in || must_ref;
         default: ;
      endcase
      gt_load = act_go | rw_go | pre_go | ref_go | prea_go | pdx_go;
      gt_val  = 14'h0;
      if (ref_go) begin
         gt_val = 14'(ddr3_timing_pkg::N_REF_GAP);
      end else if (act_go) begin
         gt_val = 14'(ddr3_timing_pkg::N_RCD);
      end else if (rw_go) begin
         // Auto precharge lets the device close the row; wait it out
         gt_val = lat_ap_q ? 14'(ddr3_timing_pkg::N_RAS + ddr3_timing_pkg::N_RP)
                           : 14'(ddr3_timing_pkg::N_RAS);
      end else if (pre_go || prea_go) begin
         gt_val = 14'(ddr3_timing_pkg::N_RP);
      end else if (pdx_go) begin
         gt_val = 14'(ddr3_timing_pkg::N_XPDLL);
      end
   end

   cycle_timer #(.W(14)) u_gap (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (gt_load),
      .value_in   (gt_val),
      .done_out   (gt_done)
   );

   // Entry delay after refresh; DLL-off needs the longer exit delay too
   cycle_timer #(.W(8)) u_refpd (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (ref_go),
      .value_in   (dll_off_in ? 8'(ddr3_timing_pkg::N_XPDLL) : 8'(ddr3_timing_pkg::N_REFPDEN)),
      .done_out   (pdt_done)
   );

   // Latency change needs the DLL delay before any read
   cycle_timer #(.W(8)) u_dll (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (dll_off_in != dll_prev_q),
      .value_in   (8'(ddr3_timing_pkg::N_XPDLL)),
      .done_out   (dll_done)
   );

   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_wr
         assign wr_load[b] = rw_go && lat_write_q && (ba_q == 3'(b));
         cycle_timer #(.W(8)) u_wr (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .load_in    (wr_load[b]),
            .value_in   (ddr3_timing_pkg::wr_window(WL, bl_mode_in, dll_off_in)),
            .done_out   (wr_done[b])
         );
      end
   endgenerate

   // Power-up: reset pin low, then clock enable low, then run
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         init_q    <= 14'h0;
         mem_rst_q <= 1'b0;
      end else if (state_q == ST_RESET) begin
         init_q <= init_q + 14'h1;
         if (init_q == 14'(INIT_RESET - 1)) begin
            init_q    <= 14'h0;
            mem_rst_q <= 1'b1;
         end
      end else if (state_q == ST_CKE) begin
         init_q <= init_q + 14'h1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ST_RESET;
      end else begin
         case (state_q)
            ST_RESET: if (init_q == 14'(INIT_RESET - 1)) state_q <= ST_CKE;
            ST_CKE:   if (init_q == 14'(INIT_CKE - 1)) state_q <= ST_IDLE;
            ST_IDLE: begin
               if (ref_go) begin
                  state_q <= ddr3_timing_pkg::PREA_AFTER_REF ? ST_REF : ST_IDLE;
               end else if (pd_go) begin
                  state_q <= ST_PD;
               end else if (act_go) begin
                  state_q <= ST_ACT;
               end
            end
            ST_ACT:   if (rw_go) state_q <= lat_ap_q ? ST_IDLE : ST_PRE;
            ST_PRE:   if (pre_go) state_q <= ST_IDLE;
            ST_REF:   if (prea_go) state_q <= ST_IDLE;
            ST_PD:    if (pdx_go) state_q <= ST_IDLE;
            default:  state_q <= ST_RESET;
         endcase
      end
   end

   // Command bus, one command per go except power-down entry and exit, NOP otherwise
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cmd_q       <= ddr3_timing_pkg::CMD_NOP;
         ba_q        <= 3'h0;
         a_q         <= 14'h0;
         lat_write_q <= 1'b0;
         lat_ap_q    <= 1'b0;
         lat_bc4_q   <= 1'b0;
         lat_col_q   <= 10'h0;
      end else begin
         cmd_q <= ddr3_timing_pkg::CMD_NOP;
         if (act_go) begin
            cmd_q       <= ddr3_timing_pkg::CMD_ACT;
            ba_q        <= req_bank_in;
            a_q         <= req_row_in;
            lat_write_q <= req_write_in;
            lat_ap_q    <= req_ap_in;
            lat_bc4_q   <= req_bc4_in;
            lat_col_q   <= req_col_in;
         end else if (rw_go) begin
            cmd_q                         <= lat_write_q ? ddr3_timing_pkg::CMD_WR : ddr3_timing_pkg::CMD_RD;
            a_q                           <= {4'h0, lat_col_q};
            a_q[ddr3_timing_pkg::A_AP]    <= lat_ap_q;
            a_q[ddr3_timing_pkg::A_BL8]   <= !(bl_mode_in == ddr3_timing_pkg::BL_OTF && lat_bc4_q);
         end else if (pre_go) begin
            cmd_q                      <= ddr3_timing_pkg::CMD_PRE;
            a_q[ddr3_timing_pkg::A_AP] <= 1'b0;
         end else if (ref_go) begin
            cmd_q <= ddr3_timing_pkg::CMD_REF;
         end else if (prea_go) begin
            cmd_q                      <= ddr3_timing_pkg::CMD_PRE;
            a_q[ddr3_timing_pkg::A_AP] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cke_q <= 1'b0;
      end else if ((state_q == ST_CKE && init_q == 14'(INIT_CKE - 1)) || pdx_go) begin
         cke_q <= 1'b1;
      end else if (pd_go) begin
         cke_q <= 1'b0;
      end
   end

   // Refresh interval tick; hot parts refresh twice as often
   assign tick = (refi_q == (hot_in ? 8'(ddr3_timing_pkg::N_REFI_HOT - 1)
                                    : 8'(ddr3_timing_pkg::N_REFI - 1)));

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         refi_q <= 8'h0;
      end else if (tick || state_q == ST_RESET || state_q == ST_CKE) begin
         refi_q <= 8'h0;
      end else begin
         refi_q <= refi_q + 8'h1;
      end
   end

   // Tick and refresh in the same cycle cancel out
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         debt_q <= 4'h0;
      end else if (tick && !ref_go) begin
         debt_q <= debt_q + 4'h1;
      end else if (ref_go && !tick) begin
         debt_q <= debt_q - 4'h1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dll_prev_q       <= 1'b0;
         req_ack_out      <= 1'b0;
         refresh_debt_out <= 4'h0;
         pd_active_out    <= 1'b0;
         init_done_out    <= 1'b0;
      end else begin
         dll_prev_q       <= dll_off_in;
         req_ack_out      <= act_go;
         refresh_debt_out <= debt_q;
         pd_active_out    <= pd_go || (pd_active_out && !pdx_go);
         init_done_out    <= (state_q != ST_RESET) && (state_q != ST_CKE);
      end
   end

   assign mem.reset_n = mem_rst_q;
   assign mem.cke     = cke_q;
   assign mem.cs_n    = cmd_q[3];
   assign mem.ras_n   = cmd_q[2];
   assign mem.cas_n   = cmd_q[1];
   assign mem.we_n    = cmd_q[0];
   assign mem.ba      = ba_q;
   assign mem.a       = a_q;
endmodule

// ===== hw/ddr3_timing_pkg.sv
package ddr3_timing_pkg;

   // Clock and printed times, all in picoseconds
   localparam int T_CK_PS       = 50000;
   localparam int T_WR_PS       = 15000;
   localparam int T_RAS_PS      = 35000;
   localparam int T_RCD_PS      = 13750;
   localparam int T_RP_PS       = 13750;
   localparam int T_RFC_PS      = 160000;
   localparam int T_XPDLL_PS    = 24000;
   localparam int T_REFI_PS     = 7812500;
   localparam int T_REFI_HOT_PS = 3906250;
   localparam int T_SLOW_CK_PS  = 40000;
   localparam int T_RESET_PS    = 200000000;
   localparam int T_CKE_PS      = 500000000;

   // Figures given in clocks
   localparam int N_WR_DLLOFF_MIN = 4;
   localparam int N_XPDLL_MIN     = 10;
   localparam int N_REFPDEN       = 1;
   localparam int N_POSTPONE_MAX  = 8;
   localparam int N_START_BL8     = 4;
   localparam int N_START_BC4_FIX = 2;

   // Least times round up, longest times round down
   function automatic int ck_min(input int ps);
      int n;
      n = (ps + T_CK_PS - 1) / T_CK_PS;
      return (n < 1) ? 1 : n;
   endfunction

   function automatic int ck_max(input int ps);
      int n;
      n = ps / T_CK_PS;
      return (n < 1) ? 1 : n;
   endfunction

   localparam int N_WR       = ck_min(T_WR_PS);
   localparam int N_RAS      = ck_min(T_RAS_PS);
   localparam int N_RCD      = ck_min(T_RCD_PS);
   localparam int N_RP       = ck_min(T_RP_PS);
   localparam int N_RFC      = ck_min(T_RFC_PS);
   localparam int N_XPDLL    = (ck_min(T_XPDLL_PS) > N_XPDLL_MIN) ? ck_min(T_XPDLL_PS) : N_XPDLL_MIN;
   localparam int N_REFI     = ck_max(T_REFI_PS);
   localparam int N_REFI_HOT = ck_max(T_REFI_HOT_PS);
   localparam int N_RESET    = ck_min(T_RESET_PS);
   localparam int N_CKE      = ck_min(T_CKE_PS);
   localparam int N_REF_GAP  = (T_CK_PS > T_RFC_PS) ? 2 : N_RFC;
   localparam bit PREA_AFTER_REF = (T_CK_PS > T_SLOW_CK_PS);

   // Command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;

   // Address bits: auto precharge / all banks, burst length on the fly
   localparam int A_AP  = 10;
   localparam int A_BL8 = 12;

   // Burst setting
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF  = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;

   // Cycles from write command until precharge may follow
   function automatic logic [7:0] wr_window(input int wl, input logic [1:0] bl_mode,
                                            input logic dll_off);
      int start;
      int twr;
      start = (bl_mode == BL_FIX4) ? N_START_BC4_FIX : N_START_BL8;
      twr   = (dll_off && N_WR < N_WR_DLLOFF_MIN) ? N_WR_DLLOFF_MIN : N_WR;
      return 8'(wl + start + twr);
   endfunction

endpackage

// ===== hw/ddr3_cmd_if.sv
`timescale 1ns/10ps
interface ddr3_cmd_if;
   logic       reset_n;
   logic       cke;
   logic       cs_n;
   logic       ras_n;
   logic       cas_n;
   logic       we_n;
   logic [2:0] ba;
   logic [13:0] a;

   modport ctrl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, a);
   modport dram (input  reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, a);
endinterface

// ===== hw/cycle_timer.sv
`timescale 1ns/10ps
module cycle_timer #(
   parameter int W = 8
) (
   input  wire logic         clk_in,
   input  wire logic         reset_n_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] value_in,
   output logic              done_out
);
   logic [W-1:0] cnt_q;

   // Done stays low for exactly value_in cycles after the loading edge
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
      end else if (load_in) begin
         cnt_q <= value_in;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign done_out = (cnt_q == '0);
endmodule

// ===== hw/ddr3_dram_end.sv
`timescale 1ns/10ps
module ddr3_dram_end #(
   parameter int WL = 5
) (
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   ddr3_cmd_if.dram        mem,
   input  wire logic [1:0] bl_mode_in,
   input  wire logic       dll_off_in,
   output logic [7:0]      bank_open_out,
   output logic            int_pre_out,
   output logic [2:0]      int_pre_bank_out,
   output logic            outputs_hiz_out,
   output logic [15:0]     refresh_count_out,
   output logic            early_pre_out
);
   logic [3:0] cmd;
   logic       live;
   logic [7:0] ras_load;
   logic [7:0] wr_load;
   logic [7:0] ras_done;
   logic [7:0] wr_done;
   logic [7:0] ap_pend_q;
   logic [7:0] ap_ready;
   logic [7:0] open_q;

   assign live = mem.reset_n && mem.cke;
   assign cmd  = live ? {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n} : ddr3_timing_pkg::CMD_NOP;

   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bank
         assign ras_load[b] = (cmd == ddr3_timing_pkg::CMD_ACT) && (mem.ba == 3'(b));
         assign wr_load[b]  = (cmd == ddr3_timing_pkg::CMD_WR) && (mem.ba == 3'(b));
         assign ap_ready[b] = ap_pend_q[b] && ras_done[b] && wr_done[b];
         cycle_timer #(.W(8)) u_ras (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .load_in    (ras_load[b]),
            .value_in   (8'(ddr3_timing_pkg::N_RAS)),
            .done_out   (ras_done[b])
         );
         // Write recovery starts WL plus two or four edges after the command
         cycle_timer #(.W(8)) u_wr (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .load_in    (wr_load[b]),
            .value_in   (ddr3_timing_pkg::wr_window(WL, bl_mode_in, dll_off_in)),
            .done_out   (wr_done[b])
         );
      end
   endgenerate

   // Bank state and the held-off internal precharge
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         open_q           <= '0;
         ap_pend_q        <= '0;
         int_pre_out      <= 1'b0;
         int_pre_bank_out <= 3'h0;
      end else begin
         int_pre_out <= 1'b0;
         // Lowest pending bank first; one internal precharge per cycle
         for (int i = 7; i >= 0; i--) begin
            if (ap_ready[i]) begin
               int_pre_out      <= 1'b1;
               int_pre_bank_out <= 3'(i);
            end
         end
         for (int i = 0; i < 8; i++) begin
            if (ap_ready[i] && (ap_ready & ((8'h1 << i) - 8'h1)) == 8'h0) begin
               open_q[i]    <= 1'b0;
               ap_pend_q[i] <= 1'b0;
            end
         end
         case (cmd)
            ddr3_timing_pkg::CMD_ACT: open_q[mem.ba] <= 1'b1;
            ddr3_timing_pkg::CMD_RD,
            ddr3_timing_pkg::CMD_WR: begin
               if (mem.a[ddr3_timing_pkg::A_AP]) begin
                  ap_pend_q[mem.ba] <= 1'b1;
               end
            end
            ddr3_timing_pkg::CMD_PRE: begin
               if (mem.a[ddr3_timing_pkg::A_AP]) begin
                  open_q <= '0;
               end else begin
                  open_q[mem.ba] <= 1'b0;
               end
            end
            default: ;
         endcase
         if (!mem.reset_n) begin
            open_q    <= '0;
            ap_pend_q <= '0;
         end
      end
   end

   // Sticky flag: precharge inside write recovery or refresh with a row open
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         early_pre_out <= 1'b0;
      end else if (cmd == ddr3_timing_pkg::CMD_PRE) begin
         if (mem.a[ddr3_timing_pkg::A_AP] ? (wr_done != 8'hff) : !wr_done[mem.ba]) begin
            early_pre_out <= 1'b1;
         end
      end else if (cmd == ddr3_timing_pkg::CMD_REF && open_q != 8'h0) begin
         early_pre_out <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         refresh_count_out <= 16'h0;
      end else if (cmd == ddr3_timing_pkg::CMD_REF) begin
         refresh_count_out <= refresh_count_out + 16'h1;
      end
   end

   // Outputs float while the reset pin is low
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         outputs_hiz_out <= 1'b1;
      end else begin
         outputs_hiz_out <= !mem.reset_n;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bank_open_out <= 8'h0;
      end else begin
         bank_open_out <= open_q;
      end
   end
endmodule

// ===== test/ddr3_refresh_recovery_timing_props.sv
`timescale 1ns/10ps
module ddr3_refresh_recovery_timing_props (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        reset_n,
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  ba,
   input  wire logic [13:0] a
);
   localparam int REF_SPAN = 1406;
   logic [3:0]  cmd;
   logic        is_ref;
   logic        is_wr;
   logic [11:0] since_ref_q;
   logic        cke_seen_q;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign is_ref = (cmd == ddr3_timing_pkg::CMD_REF);
   assign is_wr = (cmd == ddr3_timing_pkg::CMD_WR);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cke_seen_q <= 1'b0;
      end else if (cke) begin
         cke_seen_q <= 1'b1;
      end
   end
   // Saturates, so a refresh that never comes still trips the limit
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         since_ref_q <= 12'h000;
      end else if (is_ref || !cke_seen_q) begin
         since_ref_q <= 12'h000;
      end else if (since_ref_q != 12'hfff) begin
         since_ref_q <= since_ref_q + 12'h001;
      end
   end
   property p_ref_prea;
      is_ref |-> ##5 (cmd == ddr3_timing_pkg::CMD_PRE && a[10]);
   endproperty
   a_ref_prea: assert property (p_ref_prea) else $error("no precharge-all after refresh");
   property p_ref_gap;
      is_ref |=> (!is_ref)[*4];
   endproperty
   a_ref_gap: assert property (p_ref_gap) else $error("refreshes too close");
   property p_wr_hold;
      is_wr |=> (cmd != ddr3_timing_pkg::CMD_PRE)[*7];
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("precharge inside write recovery");
   property p_act_cas;
      cmd == ddr3_timing_pkg::CMD_ACT |-> ##2 (cmd == ddr3_timing_pkg::CMD_RD || is_wr);
   endproperty
   a_act_cas: assert property (p_act_cas) else $error("no column command after activate");
   property p_init_cke;
      $rose(reset_n) |-> (!cke)[*3];
   endproperty
   a_init_cke: assert property (p_init_cke) else $error("cke high too soon after memory reset");
   property p_ref_cke;
      is_ref |=> cke[*4];
   endproperty
   a_ref_cke: assert property (p_ref_cke) else $error("cke dropped right after refresh");
   property p_pd_exit;
      $rose(cke) && cke_seen_q |-> (cmd == ddr3_timing_pkg::CMD_NOP)[*8];
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("command too soon after power-down exit");
   property p_ref_span;
      since_ref_q < REF_SPAN;
   endproperty
   a_ref_span: assert property (p_ref_span) else $error("refresh gap too long");
   c_ref: cover property (is_ref);
   c_wr: cover property (is_wr);
   c_pd: cover property ($fell(cke) && cke_seen_q);
endmodule

// ===== test/ddr3_refresh_recovery_timing_tb.sv
`timescale 1ns/10ps
module ddr3_refresh_recovery_timing_tb;
   localparam int WL = 5;
   logic        clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        req_valid = 1'b0, req_write = 1'b0, req_ap = 1'b0, req_bc4 = 1'b0;
   logic [2:0]  req_bank = 3'h0;
   logic [13:0] req_row = 14'h0000;
   logic        pd_req = 1'b0, hot = 1'b0, dll_off = 1'b0;
   logic [1:0]  bl_mode = 2'h0;
   logic        req_ack, pd_active, init_done, int_pre, hiz_bad, early_pre, early_bad;
   logic [2:0]  int_pre_bank, ap_bank;
   logic [15:0] ref_cnt;
   logic [3:0]  cmd;
   int          failures = 0;
   int          comparisons = 0;
   int          cyc = 0, wr_at = 0, gap = 0, n, r0;
   ddr3_cmd_if  mif();
   ddr3_cmd_if  fif();
   always #25 clk_in = ~clk_in;
   assign cmd = {mif.cs_n, mif.ras_n, mif.cas_n, mif.we_n};
   ddr3_ctrl_end #(.WL(WL), .INIT_RESET(4), .INIT_CKE(4)) i_ddr3_ctrl_end (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .mem(mif.ctrl), .req_valid_in(req_valid),
      .req_write_in(req_write), .req_ap_in(req_ap), .req_bc4_in(req_bc4), .req_bank_in(req_bank),
      .req_row_in(req_row), .req_col_in(10'h008), .pd_req_in(pd_req), .hot_in(hot), .dll_off_in(dll_off),
      .bl_mode_in(bl_mode), .req_ack_out(req_ack), .refresh_debt_out(), .pd_active_out(pd_active),
      .init_done_out(init_done));
   ddr3_dram_end #(.WL(WL)) i_ddr3_dram_end (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .mem(mif.dram), .bl_mode_in(bl_mode), .dll_off_in(dll_off),
      .bank_open_out(), .int_pre_out(int_pre), .int_pre_bank_out(int_pre_bank), .outputs_hiz_out(),
      .refresh_count_out(ref_cnt), .early_pre_out(early_pre));
   // Second memory end, fed by the bench to break write recovery on purpose
   ddr3_dram_end #(.WL(WL)) i_ddr3_dram_end_bad (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .mem(fif.dram), .bl_mode_in(bl_mode), .dll_off_in(dll_off),
      .bank_open_out(), .int_pre_out(), .int_pre_bank_out(), .outputs_hiz_out(hiz_bad),
      .refresh_count_out(), .early_pre_out(early_bad));
   ddr3_refresh_recovery_timing_props i_ddr3_refresh_recovery_timing_props (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .reset_n(mif.reset_n), .cke(mif.cke), .cs_n(mif.cs_n),
      .ras_n(mif.ras_n), .cas_n(mif.cas_n), .we_n(mif.we_n), .ba(mif.ba), .a(mif.a));
   // Sampled mid-cycle, clear of the launching edge
   always @(negedge clk_in) begin
      cyc = cyc + 1;
      if (cmd === ddr3_timing_pkg::CMD_WR) wr_at = cyc;
      if (cmd === ddr3_timing_pkg::CMD_PRE && mif.a[10] === 1'b0) gap = cyc - wr_at;
      if (int_pre === 1'b1) ap_bank = int_pre_bank;
   end
   task automatic step(input int k);
      repeat (k) @(posedge clk_in);
      #2;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic access(input logic wr, input logic ap, input logic [2:0] bank);
      req_valid = 1'b1;
      req_write = wr;
      req_ap = ap;
      req_bank = bank;
      req_row = 14'(bank) << 4;
      n = 0;
      do begin
         step(1);
         n++;
      end while (req_ack !== 1'b1 && n < 2000);
      req_valid = 1'b0;
      chk("ack", 16'h1, 16'(req_ack));
      step(20);
   endtask
   task automatic fcmd(input logic [3:0] c, input logic [13:0] addr);
      {fif.cs_n, fif.ras_n, fif.cas_n, fif.we_n} = c;
      fif.a = addr;
      step(1);
   endtask
   task automatic results();
      $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (12000) @(posedge clk_in);
      failures++;
      results();
   end
   initial begin
      fif.reset_n = 1'b0;
      fif.cke = 1'b0;
      fif.ba = 3'h0;
      fif.a = 14'h0;
      {fif.cs_n, fif.ras_n, fif.cas_n, fif.we_n} = 4'h7;
      step(5);
      reset_n_in = 1'b1;
      chk("hiz_bad", 16'h1, 16'(hiz_bad));
      fif.reset_n = 1'b1;
      fif.cke = 1'b1;
      fcmd(ddr3_timing_pkg::CMD_ACT, 14'h0);
      fcmd(ddr3_timing_pkg::CMD_WR, 14'h1000);
      fcmd(ddr3_timing_pkg::CMD_NOP, 14'h0);
      fcmd(ddr3_timing_pkg::CMD_PRE, 14'h0);
      fcmd(ddr3_timing_pkg::CMD_NOP, 14'h0);
      step(4);
      chk("early_bad", 16'h1, 16'(early_bad));
      chk("init_done", 16'h1, 16'(init_done));
      $display("Test fault done");
      // Mode 3 stands for on-the-fly with a four-beat chop
      for (int m = 0; m < 4; m++) begin
         for (int d = 0; d < 2; d++) begin
            bl_mode = (m == 3) ? ddr3_timing_pkg::BL_OTF : 2'(m);
            req_bc4 = (m == 3);
            dll_off = d[0];
            step(12);
            access(1'b1, 1'b0, 3'(m));
            // One decision cycle after the window closes
            chk("wr_to_pre", 16'(WL + (m == 2 ? 2 : 4) + (d ? 4 : 1) + 1), 16'(gap));
         end
      end
      $display("Test write recovery done");
      bl_mode = 2'h0;
      dll_off = 1'b0;
      step(12);
      access(1'b0, 1'b1, 3'h5);
      chk("ap_bank", 16'h5, 16'(ap_bank));
      access(1'b1, 1'b1, 3'h6);
      chk("ap_bank", 16'h6, 16'(ap_bank));
      $display("Test auto precharge done");
      for (int h = 0; h < 2; h++) begin
         hot = h[0];
         step(160);
         r0 = ref_cnt;
         step(1560);
         n = ref_cnt - r0;
         chk("ref_rate", 16'h1, 16'(n >= (h ? 19 : 9) && n <= (h ? 21 : 11)));
      end
      hot = 1'b0;
      $display("Test refresh done");
      pd_req = 1'b1;
      step(20);
      chk("pd_active", 16'h1, 16'(pd_active));
      chk("cke", 16'h0, 16'(mif.cke));
      pd_req = 1'b0;
      step(20);
      chk("pd_active", 16'h0, 16'(pd_active));
      chk("early_pre", 16'h0, 16'(early_pre));
      $display("Test power-down done");
      results();
   end
endmodule
